// ---- design/crcid_pkg.sv ----
// Constants, types and decode helpers for the checksum pause/continue and
// identification command block. Assumes a 10 MHz system clock and a host
// serial link far slower than it.
package crcid_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_PAUSE        = 8'h75;
  localparam logic [7:0] OP_CONTINUE     = 8'h7a;
  localparam logic [7:0] OP_READ_IDENT   = 8'h9f;
  localparam logic [7:0] OP_READ_UNIQUE  = 8'h4c;
  localparam logic [7:0] OP_WRITE_SERIAL = 8'hc2;
  localparam logic [7:0] OP_READ_SERIAL  = 8'hc3;
  localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;

  // ----------------------------------------------------------------
  // Identification field positions and sizes
  // ----------------------------------------------------------------
  localparam int ID_MAKER_LSB   = 21;
  localparam int ID_PRODUCT_LSB = 8;
  localparam int ID_DENSITY_LSB = 3;
  localparam int ID_REV_LSB     = 0;
  localparam logic [3:0] WORD_BYTES = 4'h8;
  localparam logic [63:0] SERIAL_RESET = 64'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 100;
  localparam int PAUSE_TIME_NS    = 2000;
  localparam int CONTINUE_TIME_NS = 2000;
  localparam int PAUSE_CYCLES_I =
    (PAUSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONTINUE_CYCLES_I =
    (CONTINUE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] PAUSE_CYCLES    = 8'(PAUSE_CYCLES_I);
  localparam logic [7:0] CONTINUE_CYCLES = 8'(CONTINUE_CYCLES_I);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CK_IDLE, CK_RUN, CK_PAUSING, CK_PAUSED, CK_RESUMING
  } crcid_calc_t;

  typedef enum logic [1:0] {
    FR_OPCODE, FR_DUMMY, FR_DATA, FR_IGNORE
  } crcid_phase_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Whether an opcode this block owns may run in the given calc state
  function automatic logic crcid_allowed(input logic [7:0] op,
                                         input crcid_calc_t st);
    logic ok;
    ok = 1'b0;
    unique case (st)
      CK_IDLE:
        ok = (op != OP_CONTINUE);
      CK_PAUSED:
        ok = (op == OP_CONTINUE) || (op == OP_READ_IDENT) ||
             (op == OP_READ_SERIAL);
      CK_RUN, CK_PAUSING, CK_RESUMING:
        ok = (op == OP_PAUSE);
    endcase
    return ok;
  endfunction

  // Latency code to dummy cycle count
  function automatic logic [2:0] crcid_dummy(input logic [1:0] code);
    return {1'b0, code};
  endfunction

  // Byte of a 64-bit word, zero past the eighth byte
  function automatic logic [7:0] crcid_byte(input logic [63:0] word,
                                            input logic [3:0] idx);
    logic [7:0] b;
    b = 8'h00;
    if (idx < WORD_BYTES) begin
      b = word[{idx[2:0], 3'h0} +: 8];
    end
    return b;
  endfunction

endpackage

// ---- design/crcid_top.sv ----
// Serial command front end for checksum pause/continue and for the
// identification, unique number and serial number commands, plus the byte
// FIFO that feeds read data to the output shifter.
// Assumes SPI mode 0 from the host, a link clock much slower than clock_in,
// and a checksum engine on clock_in that advances only while told to run.
`timescale 1ns/100ps

// ------------------------------------------------------------------
// Byte FIFO
// ------------------------------------------------------------------
module crcid_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  input  wire logic             flush_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_out = (count_reg != '0);
  assign out_data_out  = mem_reg[rd_ptr_reg];
  assign push = in_valid_in && in_ready_out && !flush_in;
  assign pop  = out_ready_in && out_valid_out && !flush_in;

  always_ff @(posedge clock_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in || flush_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// ------------------------------------------------------------------
// Top
// ------------------------------------------------------------------
module crcid_top #(
  parameter logic [10:0] MAKER_CODE   = 11'h155, // Arbitrary value
  parameter logic [12:0] PRODUCT_CODE = 13'h0a5a, // Arbitrary value
  parameter logic [4:0]  DENSITY_CODE = 5'h0c,
  parameter logic [2:0]  DIE_REV      = 3'h1,
  parameter logic [63:0] UNIQUE_ID    = 64'h0123_4567_89ab_cdef,
  parameter int          FIFO_DEPTH   = 8
) (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic        cs_n_in,
  input  wire logic        sck_in,
  input  wire logic        si_in,
  input  wire logic [1:0]  register_latency_code_in,
  input  wire logic        calc_start_in,
  input  wire logic        calc_done_in,
  output logic             so_out,
  output logic             so_oe_out,
  output logic             calc_run_out,
  output logic             op_in_progress_flag_out,
  output logic             checksum_paused_flag_out,
  output logic             write_enable_latch_out,
  output logic [63:0]      serial_number_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers and link edges
  // ----------------------------------------------------------------
  logic cs_meta_reg, cs_sync_reg, cs_prev_reg;
  logic sck_meta_reg, sck_sync_reg, sck_prev_reg;
  logic si_meta_reg, si_sync_reg;
  logic sck_rise, sck_fall, cs_rise, selected;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cs_meta_reg  <= 1'b1;
      cs_sync_reg  <= 1'b1;
      cs_prev_reg  <= 1'b1;
      sck_meta_reg <= 1'b0;
      sck_sync_reg <= 1'b0;
      sck_prev_reg <= 1'b0;
      si_meta_reg  <= 1'b0;
      si_sync_reg  <= 1'b0;
    end else begin
      cs_meta_reg  <= cs_n_in;
      cs_sync_reg  <= cs_meta_reg;
      cs_prev_reg  <= cs_sync_reg;
      sck_meta_reg <= sck_in;
      sck_sync_reg <= sck_meta_reg;
      sck_prev_reg <= sck_sync_reg;
      si_meta_reg  <= si_in;
      si_sync_reg  <= si_meta_reg;
    end
  end

  assign selected = !cs_sync_reg;
  assign sck_rise = selected && sck_sync_reg && !sck_prev_reg;
  assign sck_fall = selected && !sck_sync_reg && sck_prev_reg;
  assign cs_rise  = cs_sync_reg && !cs_prev_reg;

  // ----------------------------------------------------------------
  // Checksum pause/continue control
  // ----------------------------------------------------------------
  crcid_pkg::crcid_calc_t calc_reg, calc_next;
  logic [7:0] timer_reg, timer_next;
  logic       pause_cmd, continue_cmd;

  always_comb begin
    calc_next  = calc_reg;
    timer_next = timer_reg;
    unique case (calc_reg)
      crcid_pkg::CK_IDLE: begin
        if (calc_start_in) begin
          calc_next = crcid_pkg::CK_RUN;
        end
      end
      crcid_pkg::CK_RUN: begin
        if (calc_done_in) begin
          calc_next = crcid_pkg::CK_IDLE;
        end else if (pause_cmd) begin
          calc_next  = crcid_pkg::CK_PAUSING;
          timer_next = crcid_pkg::PAUSE_CYCLES - 8'h01;
        end
      end
      crcid_pkg::CK_PAUSING: begin
        if (calc_done_in) begin
          calc_next = crcid_pkg::CK_IDLE;
        end else if (timer_reg == 8'h00) begin
          calc_next = crcid_pkg::CK_PAUSED;
        end else begin
          timer_next = timer_reg - 8'h01;
        end
      end
      crcid_pkg::CK_PAUSED: begin
        if (continue_cmd) begin
          calc_next  = crcid_pkg::CK_RESUMING;
          timer_next = crcid_pkg::CONTINUE_CYCLES - 8'h01;
        end
      end
      crcid_pkg::CK_RESUMING: begin
        if (timer_reg == 8'h00) begin
          calc_next = crcid_pkg::CK_RUN;
        end else begin
          timer_next = timer_reg - 8'h01;
        end
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      calc_reg  <= crcid_pkg::CK_IDLE;
      timer_reg <= 8'h00;
    end else begin
      calc_reg  <= calc_next;
      timer_reg <= timer_next;
    end
  end

  // Flags follow the next state so they change with the state itself
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      calc_run_out             <= 1'b0;
      op_in_progress_flag_out  <= 1'b0;
      checksum_paused_flag_out <= 1'b0;
    end else begin
      // Engine keeps going while the pause is processed
      calc_run_out <= (calc_next == crcid_pkg::CK_RUN) ||
                      (calc_next == crcid_pkg::CK_PAUSING);
      op_in_progress_flag_out <=
        (calc_next == crcid_pkg::CK_RUN) ||
        (calc_next == crcid_pkg::CK_PAUSING) ||
        (calc_next == crcid_pkg::CK_RESUMING);
      checksum_paused_flag_out <=
        (calc_next == crcid_pkg::CK_PAUSED);
    end
  end

  // ----------------------------------------------------------------
  // Frame decoder
  // ----------------------------------------------------------------
  crcid_pkg::crcid_phase_t phase_reg;
  logic [7:0]  op_sh_reg;
  logic [7:0]  cmd_reg;
  logic [2:0]  bit_cnt_reg;
  logic [2:0]  dummy_reg;
  logic [7:0]  rx_reg;
  logic [63:0] stage_reg;
  logic [3:0]  wr_bytes_reg;
  logic        reading_reg;
  logic        writing_reg;
  logic        op_done;
  logic [7:0]  op_now;
  logic        op_ok;
  logic        is_read;
  logic [2:0]  dummy_now;

  assign op_now  = {op_sh_reg[6:0], si_sync_reg};
  assign op_done = sck_rise && (phase_reg == crcid_pkg::FR_OPCODE) &&
                   (bit_cnt_reg == 3'h7);
  // State passed as an argument so the assign follows calc_reg changes
  assign op_ok   = crcid_pkg::crcid_allowed(op_now, calc_reg);
  assign is_read = (op_now == crcid_pkg::OP_READ_IDENT) ||
                   (op_now == crcid_pkg::OP_READ_UNIQUE) ||
                   (op_now == crcid_pkg::OP_READ_SERIAL);
  assign dummy_now = crcid_pkg::crcid_dummy(register_latency_code_in);
  assign pause_cmd    = op_done && op_ok &&
                        (op_now == crcid_pkg::OP_PAUSE);
  assign continue_cmd = op_done && op_ok &&
                        (op_now == crcid_pkg::OP_CONTINUE);

  always_ff @(posedge clock_in) begin
    if (rst_in || !selected) begin
      phase_reg   <= crcid_pkg::FR_OPCODE;
      bit_cnt_reg <= 3'h0;
      op_sh_reg   <= 8'h00;
      dummy_reg   <= 3'h0;
      reading_reg <= 1'b0;
    end else if (sck_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      unique case (phase_reg)
        crcid_pkg::FR_OPCODE: begin
          op_sh_reg <= op_now;
          if (bit_cnt_reg == 3'h7) begin
            if (op_ok && is_read) begin
              reading_reg <= 1'b1;
              bit_cnt_reg <= 3'h0;
              dummy_reg   <= dummy_now;
              phase_reg   <= (dummy_now == 3'h0) ?
                             crcid_pkg::FR_DATA :
                             crcid_pkg::FR_DUMMY;
            end else if (op_ok &&
                         op_now == crcid_pkg::OP_WRITE_SERIAL) begin
              bit_cnt_reg <= 3'h0;
              phase_reg   <= crcid_pkg::FR_DATA;
            end else begin
              phase_reg <= crcid_pkg::FR_IGNORE;
            end
          end
        end
        crcid_pkg::FR_DUMMY: begin
          bit_cnt_reg <= 3'h0;
          dummy_reg   <= dummy_reg - 3'h1;
          if (dummy_reg == 3'h1) begin
            phase_reg <= crcid_pkg::FR_DATA;
          end
        end
        crcid_pkg::FR_DATA, crcid_pkg::FR_IGNORE: begin
        end
      endcase
    end
  end

  // Opcode of the frame and whether a serial write is in progress
  always_ff @(posedge clock_in) begin
    if (rst_in || cs_rise) begin
      cmd_reg     <= 8'h00;
      writing_reg <= 1'b0;
    end else if (op_done) begin
      cmd_reg     <= op_now;
      writing_reg <= op_ok && (op_now == crcid_pkg::OP_WRITE_SERIAL);
    end
  end

  // Serial write capture, LSB of each byte first, first byte lowest
  always_ff @(posedge clock_in) begin
    if (rst_in || !selected) begin
      rx_reg       <= 8'h00;
      stage_reg    <= 64'h0;
      wr_bytes_reg <= 4'h0;
    end else if (sck_rise && writing_reg &&
                 phase_reg == crcid_pkg::FR_DATA) begin
      rx_reg <= {si_sync_reg, rx_reg[7:1]};
      if (bit_cnt_reg == 3'h7) begin
        stage_reg <= {si_sync_reg, rx_reg[7:1], stage_reg[63:8]};
        if (wr_bytes_reg != 4'hf) begin
          wr_bytes_reg <= wr_bytes_reg + 4'h1;
        end
      end
    end
  end

  // Commit needs the latch, eight whole bytes and no stray bits
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      serial_number_out <= crcid_pkg::SERIAL_RESET;
    end else if (cs_rise && writing_reg && write_enable_latch_out &&
                 wr_bytes_reg == crcid_pkg::WORD_BYTES &&
                 bit_cnt_reg == 3'h0) begin
      serial_number_out <= stage_reg;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      write_enable_latch_out <= 1'b0;
    end else if (cs_rise && cmd_reg == crcid_pkg::OP_WRITE_SERIAL) begin
      write_enable_latch_out <= 1'b0;
    end else if (op_done && op_ok &&
                 op_now == crcid_pkg::OP_WRITE_UNLOCK) begin
      write_enable_latch_out <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Read byte source into the FIFO
  // ----------------------------------------------------------------
  logic [63:0] ident_word;
  logic [63:0] src_word_reg;
  logic [3:0]  src_idx_reg;
  logic        src_active_reg;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;
  logic        fifo_pop;

  assign ident_word =
    (64'(MAKER_CODE)   << crcid_pkg::ID_MAKER_LSB) |
    (64'(PRODUCT_CODE) << crcid_pkg::ID_PRODUCT_LSB) |
    (64'(DENSITY_CODE) << crcid_pkg::ID_DENSITY_LSB) |
    (64'(DIE_REV)      << crcid_pkg::ID_REV_LSB);

  // Source stalls on a full FIFO; past the eighth byte it sends zeros
  always_ff @(posedge clock_in) begin
    if (rst_in || !selected) begin
      src_active_reg <= 1'b0;
      src_idx_reg    <= 4'h0;
      src_word_reg   <= 64'h0;
    end else if (op_done && op_ok && is_read) begin
      src_active_reg <= 1'b1;
      src_idx_reg    <= 4'h0;
      unique case (op_now)
        crcid_pkg::OP_READ_IDENT:  src_word_reg <= ident_word;
        crcid_pkg::OP_READ_UNIQUE: src_word_reg <= UNIQUE_ID;
        default:                   src_word_reg <= serial_number_out;
      endcase
    end else if (src_active_reg && fifo_in_ready &&
                 src_idx_reg != 4'hf) begin
      src_idx_reg <= src_idx_reg + 4'h1;
    end
  end

  crcid_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_in      (clock_in),
    .rst_in        (rst_in),
    .flush_in      (!selected),
    .in_valid_in   (src_active_reg),
    .in_data_in    (crcid_pkg::crcid_byte(src_word_reg, src_idx_reg)),
    .in_ready_out  (fifo_in_ready),
    .out_valid_out (fifo_out_valid),
    .out_data_out  (fifo_out_data),
    .out_ready_in  (fifo_pop)
  );

  // ----------------------------------------------------------------
  // Output shifter, changes on the falling link clock edge
  // ----------------------------------------------------------------
  logic [6:0] tx_sh_reg;
  logic [2:0] tx_cnt_reg;
  logic       tx_turn;

  assign tx_turn  = sck_fall && reading_reg &&
                    phase_reg == crcid_pkg::FR_DATA;
  assign fifo_pop = tx_turn && tx_cnt_reg == 3'h0;

  always_ff @(posedge clock_in) begin
    if (rst_in || !selected) begin
      tx_sh_reg  <= 7'h00;
      tx_cnt_reg <= 3'h0;
      so_out     <= 1'b0;
      so_oe_out  <= 1'b0;
    end else if (tx_turn) begin
      so_oe_out  <= 1'b1;
      tx_cnt_reg <= tx_cnt_reg + 3'h1;
      if (tx_cnt_reg == 3'h0) begin
        // Past the data the source still feeds zero bytes; an empty FIFO also drives zeros
        so_out    <= fifo_out_valid & fifo_out_data[0];
        tx_sh_reg <= fifo_out_valid ? fifo_out_data[7:1] : 7'h00;
      end else begin
        so_out    <= tx_sh_reg[0];
        tx_sh_reg <= {1'b0, tx_sh_reg[6:1]};
      end
    end
  end

endmodule

// ---- sim/crcid_sva.sv ----
// Port checker for crcid_top, bound in at the foot of this file.
// Assumes one clock_in domain with synchronous active-high rst_in.
`timescale 1ns/100ps
module crcid_sva (
  input wire logic        clock_in,
  input wire logic        rst_in,
  input wire logic        cs_n_in,
  input wire logic        sck_in,
  input wire logic        si_in,
  input wire logic [1:0]  register_latency_code_in,
  input wire logic        calc_start_in,
  input wire logic        calc_done_in,
  input wire logic        so_out,
  input wire logic        so_oe_out,
  input wire logic        calc_run_out,
  input wire logic        op_in_progress_flag_out,
  input wire logic        checksum_paused_flag_out,
  input wire logic        write_enable_latch_out,
  input wire logic [63:0] serial_number_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  AST_RUN_BUSY: assert property (calc_run_out |-> op_in_progress_flag_out)
    else $error("engine runs with busy flag low");
  AST_PAUSED_QUIET: assert property (checksum_paused_flag_out |->
    !op_in_progress_flag_out && !calc_run_out)
    else $error("paused with busy or run high");
  AST_PAUSE_BUSY: assert property ($rose(checksum_paused_flag_out) |->
    $past(op_in_progress_flag_out) && $past(calc_run_out))
    else $error("pause took effect without busy period");
  AST_START: assert property (calc_start_in && !op_in_progress_flag_out &&
    !checksum_paused_flag_out |=> op_in_progress_flag_out && calc_run_out)
    else $error("start did not raise busy and run");
  AST_DONE: assert property (calc_done_in && calc_run_out |=>
    !op_in_progress_flag_out && !checksum_paused_flag_out && !calc_run_out)
    else $error("finish did not leave all flags low");
  AST_RESUME: assert property ($fell(checksum_paused_flag_out) |->
    op_in_progress_flag_out && !calc_run_out ##[18:22] calc_run_out)
    else $error("continue timing wrong");
  AST_COMMIT: assert property (!$stable(serial_number_out) |->
    $fell(write_enable_latch_out))
    else $error("serial changed without latch clearing");
  AST_OE_END: assert property (cs_n_in [*5] |-> !so_oe_out)
    else $error("output enabled while deselected");
  AST_PAUSED_NO_UNLOCK: assert property (checksum_paused_flag_out |->
    !$rose(write_enable_latch_out))
    else $error("unlock accepted while paused");
endmodule

bind crcid_top crcid_sva u_chk (.clock_in(clock_in), .rst_in(rst_in),
  .cs_n_in(cs_n_in), .sck_in(sck_in), .si_in(si_in),
  .register_latency_code_in(register_latency_code_in),
  .calc_start_in(calc_start_in), .calc_done_in(calc_done_in),
  .so_out(so_out), .so_oe_out(so_oe_out), .calc_run_out(calc_run_out),
  .op_in_progress_flag_out(op_in_progress_flag_out),
  .checksum_paused_flag_out(checksum_paused_flag_out),
  .write_enable_latch_out(write_enable_latch_out),
  .serial_number_out(serial_number_out));

// ---- sim/crcid_host.sv ----
// Host side of the serial link: select, link clock and data in, mode 0.
// Assumes it shares clock_in with the bench; half a link period is 4 clocks.
`timescale 1ns/100ps
module crcid_host (
  input  wire logic clock_in,
  input  wire logic so_in,
  input  wire logic so_oe_in,
  output logic      cs_n_out,
  output logic      sck_out,
  output logic      si_out
);
  logic oe_seen;
  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    si_out = 1'b0;
    oe_seen = 1'b0;
  end
  task automatic half();
    repeat (4) @(posedge clock_in);
    #1;
  endtask
  // Data set after the fall, sampled mid-high so the reply has settled
  task automatic cyc(input logic b, output logic r);
    si_out = b;
    half();
    sck_out = 1'b1;
    repeat (2) @(posedge clock_in);
    // An undriven line reads as the inverse so a late enable shows up
    #1 r = so_oe_in ? so_in : ~so_in;
    oe_seen = oe_seen | so_oe_in;
    repeat (2) @(posedge clock_in);
    #1 sck_out = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] op, input int nd, input int nw,
                      input logic [63:0] wd, input int nr,
                      output logic [63:0] rd);
    logic r;
    rd = 64'h0;
    oe_seen = 1'b0;
    cs_n_out = 1'b0;
    for (int i = 7; i >= 0; i--) cyc(op[i], r);
    for (int i = 0; i < nd; i++) cyc(~si_out, r);
    for (int i = 0; i < nw; i++) cyc(wd[i], r);
    for (int i = 0; i < nr; i++) begin
      cyc(~si_out, r);
      rd[i] = r;
    end
    half();
    cs_n_out = 1'b1;
    si_out = ~si_out;
    half();
  endtask
endmodule

// ---- sim/tb_crc_pause_and_ident_commands.sv ----
// Self-checking bench for crcid_top: host model on the link, engine events
// from the bench, expected values kept in bench variables.
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_crc_pause_and_ident_commands;
  localparam logic [10:0] MAKER = 11'h2a3;  // Arbitrary value
  localparam logic [12:0] PROD  = 13'h1b4c; // Arbitrary value
  localparam logic [63:0] UID   = 64'hfeed_0042_1357_9bdf;
  localparam logic [63:0] IDW   = {32'h0, MAKER, PROD, 5'h0c, 3'h1};
  logic        clock_in, rst_in, cs_n, sck, si, start, done, so, so_oe;
  logic        run, op_in_progress_flag, paused, write_enable_latch;
  logic [1:0]  lat;
  logic [63:0] sn, m_sn, rd, wd;
  int          fails = 0, num_checks = 0, cycles = 0;

  crcid_top #(.MAKER_CODE(MAKER), .PRODUCT_CODE(PROD), .DENSITY_CODE(5'h0c),
    .DIE_REV(3'h1), .UNIQUE_ID(UID), .FIFO_DEPTH(8)) DUT (
    .clock_in(clock_in), .rst_in(rst_in), .cs_n_in(cs_n), .sck_in(sck),
    .si_in(si), .register_latency_code_in(lat), .calc_start_in(start),
    .calc_done_in(done), .so_out(so), .so_oe_out(so_oe), .calc_run_out(run),
    .op_in_progress_flag_out(op_in_progress_flag), .checksum_paused_flag_out(paused),
    .write_enable_latch_out(write_enable_latch), .serial_number_out(sn));
  crcid_host host (.clock_in(clock_in), .so_in(so), .so_oe_in(so_oe),
    .cs_n_out(cs_n), .sck_out(sck), .si_out(si));

  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  // Whole run needs about 12000 cycles; the ceiling leaves ample margin
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic pulse_start();
    start = 1'b1;
    tick(1);
    start = 1'b0;
  endtask
  task automatic pulse_done();
    done = 1'b1;
    tick(1);
    done = 1'b0;
  endtask
  task automatic op(input logic [7:0] o);
    host.xfer(o, 0, 0, 64'h0, 0, rd);
  endtask

  initial begin
    rst_in = 1'b1;
    start = 1'b0;
    done = 1'b0;
    lat = 2'h0;
    m_sn = 64'h0;
    void'($urandom(32'hd34704f0));
    tick(16);
    rst_in = 1'b0;
    tick(4);
    `CHK({op_in_progress_flag, paused, run, write_enable_latch, so_oe}, 5'h00)
    `CHK(sn, m_sn)
    for (int c = 0; c < 4; c++) begin
      lat = 2'(c);
      host.xfer(8'h9f, c, 0, 64'h0, 64, rd);
      `CHK(rd, IDW)
      host.xfer(8'h4c, c, 0, 64'h0, 64, rd);
      `CHK(rd, UID)
    end
    wd = {$urandom, $urandom};
    op(crcid_pkg::OP_WRITE_UNLOCK);
    `CHK(write_enable_latch, 1'b1)
    host.xfer(8'hc2, 0, 64, wd, 0, rd);
    m_sn = wd;
    `CHK(sn, m_sn)
    `CHK(write_enable_latch, 1'b0)
    lat = 2'($urandom);
    host.xfer(8'hc3, int'(lat), 0, 64'h0, 64, rd);
    `CHK(rd, m_sn)
    host.xfer(8'hc2, 0, 64, ~wd, 0, rd);
    `CHK(sn, m_sn)
    op(crcid_pkg::OP_WRITE_UNLOCK);
    host.xfer(8'hc2, 0, 56, ~wd, 0, rd);
    `CHK(sn, m_sn)
    `CHK(write_enable_latch, 1'b0)
    op(8'h75);
    `CHK({op_in_progress_flag, run, paused}, 3'b000)
    op(8'h7a);
    `CHK({op_in_progress_flag, run, paused}, 3'b000)
    pulse_start();
    `CHK({op_in_progress_flag, run}, 2'b11)
    for (int k = 0; k < 3; k++) begin
      op(8'h75);
      `CHK({op_in_progress_flag, run, paused}, 3'b110)
      tick(25);
      `CHK({op_in_progress_flag, run, paused}, 3'b001)
      host.xfer(8'h9f, int'(lat), 0, 64'h0, 64, rd);
      `CHK(rd, IDW)
      host.xfer(8'h4c, int'(lat), 0, 64'h0, 64, rd);
      `CHK(host.oe_seen, 1'b0)
      op(crcid_pkg::OP_WRITE_UNLOCK);
      `CHK(write_enable_latch, 1'b0)
      op(8'h7a);
      `CHK({op_in_progress_flag, run, paused}, 3'b100)
      tick(25);
      `CHK({op_in_progress_flag, run, paused}, 3'b110)
    end
    pulse_done();
    tick(1);
    `CHK({op_in_progress_flag, run, paused}, 3'b000)
    pulse_start();
    op(8'h75);
    pulse_done();
    tick(25);
    `CHK({op_in_progress_flag, run, paused}, 3'b000)
    give_verdict();
  end
endmodule
